// *** rtl/ppme_defines.svh ***
// Constants of the parallel master port engine: register offsets,
// field positions and reset values.
// Assumes a byte-wide register port with a four-bit word address.
`ifndef PPME_DEFINES_SVH
`define PPME_DEFINES_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define PPME_OFS_CONTROL_HIGH 4'h0
`define PPME_OFS_CONTROL_LOW 4'h1
`define PPME_OFS_MODE_HIGH 4'h2
`define PPME_OFS_WAIT_CFG 4'h3
`define PPME_OFS_ADDR_LOW 4'h4
`define PPME_OFS_ADDR_HIGH 4'h5
`define PPME_OFS_DIN_LOW 4'h6
`define PPME_OFS_DIN_HIGH 4'h7

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define PPME_CH_ENABLE 7
`define PPME_CH_MUX_HI 4
`define PPME_CH_MUX_LO 3
`define PPME_CL_CSF_HI 7
`define PPME_CL_CSF_LO 6
`define PPME_CL_ALP 5
`define PPME_CL_CS2P 4
`define PPME_CL_CS1P 3
`define PPME_CL_BEP 2
`define PPME_CL_WRP 1
`define PPME_CL_RDP 0
`define PPME_MH_BUSY 7
`define PPME_MH_IRQ_EN 5
`define PPME_MH_INC_HI 4
`define PPME_MH_INC_LO 3
`define PPME_MH_WIDE 2
`define PPME_MH_MODE_HI 1
`define PPME_MH_MODE_LO 0
`define PPME_WC_WB_HI 7
`define PPME_WC_WB_LO 6
`define PPME_WC_WM_HI 5
`define PPME_WC_WM_LO 2
`define PPME_WC_WE_HI 1
`define PPME_WC_WE_LO 0

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define PPME_RST_REG8 8'h00
`define PPME_RST_ADDR 16'h0000

`endif

// *** rtl/ppme_pkg.sv ***
// Types of the parallel master port engine.
// Assumes the defines header supplies every number.
package ppme_pkg;

   // Bus sequence phases
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_LATCH_LO,
      PH_LATCH_HI,
      PH_SETUP,
      PH_STROBE,
      PH_HOLD
   } ppme_phase_t;

   // Engine state
   typedef struct packed {
      logic [7:0] ctrl_hi;
      logic [7:0] ctrl_lo;
      logic [7:0] mode_hi;
      logic [7:0] wait_cfg;
      logic [15:0] addr;
      logic [7:0] din_lo;
      logic [7:0] din_hi;
      logic [7:0] rdata;
      ppme_phase_t phase;
      logic second;
      logic is_wr;
      logic [7:0] data_out;
      logic data_oe;
      logic [15:0] addr_pins;
      logic rd_pin;
      logic wr_pin;
      logic be_pin;
      logic irq;
   } ppme_state_t;

   // Phase timer state
   typedef struct packed {
      logic [3:0] cnt;
   } ppme_timer_t;

endpackage

// *** rtl/ppme_phase_timer.sv ***
// Down-counter that times each phase of a bus sequence.
// Assumes the engine loads it on every phase entry.
`timescale 1ns/1ps
module ppme_phase_timer (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [3:0] load_val,
   output logic [3:0] count
);
   import ppme_pkg::*;

   ppme_timer_t t_q;
   ppme_timer_t t_d;

   // Load on phase entry, else count toward zero
   always_comb begin
      t_d = t_q;
      if (reset) begin
         t_d.cnt = 4'h0;
      end else if (load) begin
         t_d.cnt = load_val;
      end else if (t_q.cnt != 4'h0) begin
         t_d.cnt = t_q.cnt - 4'h1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      t_q <= t_d;
   end

   assign count = t_q.cnt;

endmodule

// *** rtl/ppme_engine.sv ***
// Parallel master port engine: registers, bus sequencer and pins.
// Assumes a synchronous register port with read data one cycle later.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ppme_defines.svh"
module ppme_engine (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] port_data_in,
   output logic [7:0] port_data_out,
   output logic port_data_oe,
   output logic [15:0] address_pins,
   output logic read_strobe,
   output logic write_strobe,
   output logic byte_enable_strobe,
   output logic busy,
   output logic irq_pulse
);
   import ppme_pkg::*;

   // -----------------------------------------------------------------
   // Helper functions
   // -----------------------------------------------------------------

   // Pin level from activity and polarity (1 = active high)
   function automatic logic pol_out(input logic act, input logic pol);
      return act ? pol : ~pol;
   endfunction

   // Address bits that take part in stepping
   function automatic logic [15:0] cs_mask(input logic [1:0] csf);
      logic [15:0] m;
      m = 16'hFFFF;
      if (csf != 2'b00) begin
         m[15] = 1'b0;
      end
      if (csf[1]) begin
         m[14] = 1'b0;
      end
      return m;
   endfunction

   // First phase from p on that is used: latch phases per mux, setup only with nonzero wb and wm
   function automatic ppme_phase_t live_from(input ppme_phase_t p,
         input logic [1:0] mux, input logic [1:0] wb,
         input logic [3:0] wm);
      ppme_phase_t r;
      r = p;
      if (r == PH_LATCH_LO && mux == 2'b00) begin
         r = PH_LATCH_HI;
      end
      if (r == PH_LATCH_HI && mux != 2'b10) begin
         r = PH_SETUP;
      end
      if (r == PH_SETUP && (wm == 4'h0 || wb == 2'b00)) begin
         r = PH_STROBE;
      end
      return r;
   endfunction

   // Timer load value: cycles of the phase minus one
   function automatic logic [3:0] phase_len(input ppme_phase_t p,
         input logic [1:0] wb, input logic [3:0] wm,
         input logic [1:0] we);
      logic [3:0] n;
      n = 4'h0;
      if (p == PH_SETUP) begin
         n = {2'b00, wb} - 4'h1;
      end else if (p == PH_STROBE) begin
         n = wm;
      end else if (p == PH_HOLD) begin
         n = {2'b00, we} - 4'h1;
      end
      return n;
   endfunction

   // -----------------------------------------------------------------
   // State and decoded configuration
   // -----------------------------------------------------------------
   ppme_state_t st_q;
   ppme_state_t st_d;
   logic [3:0] tcount;
   logic [3:0] tload;
   logic tload_en;
   logic master_on;
   logic [1:0] mux;
   logic [1:0] csf;
   logic [1:0] wb;
   logic [3:0] wm;
   logic [1:0] we;
   logic [1:0] increment_mode_field;
   logic wide;
   logic hold_on;
   logic step;
   logic byte_last;
   logic last;
   logic busy_w;
   logic sw_go;
   logic byte_end;
   logic op;
   logic [15:0] ap;
   logic [15:0] step_addr;
   logic [15:0] keep_mask;

   // Configuration fields
   assign master_on = st_q.ctrl_hi[`PPME_CH_ENABLE]
                      & st_q.mode_hi[`PPME_MH_MODE_HI];
   assign mux = st_q.ctrl_hi[`PPME_CH_MUX_HI:`PPME_CH_MUX_LO];
   assign csf = st_q.ctrl_lo[`PPME_CL_CSF_HI:`PPME_CL_CSF_LO];
   assign wb = st_q.wait_cfg[`PPME_WC_WB_HI:`PPME_WC_WB_LO];
   assign wm = st_q.wait_cfg[`PPME_WC_WM_HI:`PPME_WC_WM_LO];
   assign we = st_q.wait_cfg[`PPME_WC_WE_HI:`PPME_WC_WE_LO];
   assign increment_mode_field = st_q.mode_hi[`PPME_MH_INC_HI:`PPME_MH_INC_LO];
   assign wide = st_q.mode_hi[`PPME_MH_WIDE];
   assign keep_mask = cs_mask(csf);

   // Hold phase only with nonzero middle wait
   assign hold_on = (wm != 4'h0) && (we != 2'b00);

   // Phase end and last cycle of the whole operation
   assign step = (st_q.phase != PH_IDLE) && (tcount == 4'h0);
   assign byte_last = (st_q.phase == PH_STROBE && !hold_on)
                      || st_q.phase == PH_HOLD;
   assign last = step && byte_last && !(wide && !st_q.second);
   assign busy_w = (st_q.phase != PH_IDLE) && !last;
   assign sw_go = master_on && !busy_w && (reg_rd || reg_wr)
                  && reg_addr == `PPME_OFS_DIN_LOW;

   // Address after stepping, chip select bits untouched
   always_comb begin
      ap = st_q.addr;
      if (increment_mode_field == 2'b01) begin
         ap = st_q.addr + 16'h0001;
      end else if (increment_mode_field == 2'b10) begin
         ap = st_q.addr - 16'h0001;
      end
      step_addr = (st_q.addr & ~cs_mask(csf))
                  | (ap & cs_mask(csf));
   end

   // -----------------------------------------------------------------
   // Register port, sequencer and pin levels
   // -----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.irq = 1'b0;
      st_d.rdata = 8'h00;
      byte_end = 1'b0;
      op = 1'b0;
      // Register writes; busy blocks the data register
      if (reg_wr) begin
         unique case (reg_addr)
            `PPME_OFS_CONTROL_HIGH: st_d.ctrl_hi = reg_wdata & 8'h98;
            `PPME_OFS_CONTROL_LOW: st_d.ctrl_lo = reg_wdata;
            `PPME_OFS_MODE_HIGH: st_d.mode_hi = reg_wdata & 8'h3F;
            `PPME_OFS_WAIT_CFG: st_d.wait_cfg = reg_wdata;
            `PPME_OFS_ADDR_LOW: st_d.addr[7:0] = reg_wdata;
            `PPME_OFS_ADDR_HIGH: st_d.addr[15:8] = reg_wdata;
            `PPME_OFS_DIN_LOW: begin
               if (!(master_on && busy_w)) begin
                  st_d.din_lo = reg_wdata;
               end
            end
            `PPME_OFS_DIN_HIGH: st_d.din_hi = reg_wdata;
            default: ;
         endcase
      end
      // Register reads; data low gives the previous bus byte
      if (reg_rd) begin
         unique case (reg_addr)
            `PPME_OFS_CONTROL_HIGH: st_d.rdata = st_q.ctrl_hi;
            `PPME_OFS_CONTROL_LOW: st_d.rdata = st_q.ctrl_lo;
            `PPME_OFS_MODE_HIGH:
               st_d.rdata = {busy_w, st_q.mode_hi[6:0]};
            `PPME_OFS_WAIT_CFG: st_d.rdata = st_q.wait_cfg;
            `PPME_OFS_ADDR_LOW: st_d.rdata = st_q.addr[7:0];
            `PPME_OFS_ADDR_HIGH: st_d.rdata = st_q.addr[15:8];
            `PPME_OFS_DIN_LOW: st_d.rdata = st_q.din_lo;
            `PPME_OFS_DIN_HIGH: st_d.rdata = st_q.din_hi;
            default: st_d.rdata = 8'h00;
         endcase
      end
      // Phase sequencing
      if (step) begin
         unique case (st_q.phase)
            PH_IDLE: ;
            PH_LATCH_LO: st_d.phase = live_from(PH_LATCH_HI, mux, wb, wm);
            PH_LATCH_HI: st_d.phase = live_from(PH_SETUP, mux, wb, wm);
            PH_SETUP: st_d.phase = PH_STROBE;
            PH_STROBE: begin
               // Capture bus byte at strobe end
               if (!st_q.is_wr && st_q.second) begin
                  st_d.din_hi = port_data_in;
               end else if (!st_q.is_wr) begin
                  st_d.din_lo = port_data_in;
               end
               if (hold_on) begin
                  st_d.phase = PH_HOLD;
               end else begin
                  byte_end = 1'b1;
               end
            end
            PH_HOLD: byte_end = 1'b1;
         endcase
      end
      // Byte done: second byte or completion
      if (byte_end) begin
         if (wide && !st_q.second) begin
            st_d.second = 1'b1;
            st_d.phase = live_from(PH_SETUP, mux, wb, wm);
         end else begin
            st_d.phase = PH_IDLE;
            st_d.addr = step_addr;
            st_d.irq = st_q.mode_hi[`PPME_MH_IRQ_EN];
         end
      end
      // New operation from software
      if (sw_go) begin
         st_d.phase = live_from(PH_LATCH_LO, mux, wb, wm);
         st_d.second = 1'b0;
         st_d.is_wr = reg_wr;
      end
      // Pin levels for the coming cycle
      op = st_d.phase != PH_IDLE;
      st_d.addr_pins = st_d.addr;
      if (csf != 2'b00) begin
         st_d.addr_pins[15] = pol_out(op && st_d.addr[15],
                                      st_d.ctrl_lo[`PPME_CL_CS2P]);
      end
      if (csf[1]) begin
         st_d.addr_pins[14] = pol_out(op && st_d.addr[14],
                                      st_d.ctrl_lo[`PPME_CL_CS1P]);
      end
      if (mux != 2'b00) begin
         st_d.addr_pins[0] = pol_out(st_d.phase == PH_LATCH_LO,
                                     st_d.ctrl_lo[`PPME_CL_ALP]);
      end
      if (mux == 2'b10) begin
         st_d.addr_pins[1] = pol_out(st_d.phase == PH_LATCH_HI,
                                     st_d.ctrl_lo[`PPME_CL_ALP]);
      end
      // Data pins: address in latch cycles, write bytes after
      st_d.data_out = 8'h00;
      st_d.data_oe = 1'b0;
      if (st_d.phase == PH_LATCH_LO) begin
         st_d.data_out = st_d.addr[7:0];
         st_d.data_oe = 1'b1;
      end else if (st_d.phase == PH_LATCH_HI) begin
         st_d.data_out = st_d.addr[15:8] & keep_mask[15:8];
         st_d.data_oe = 1'b1;
      end else if (op && st_d.is_wr) begin
         st_d.data_out = st_d.second ? st_d.din_hi : st_d.din_lo;
         st_d.data_oe = 1'b1;
      end
      // Strobes: separate pins or direction with enable
      if (master_on && !st_q.mode_hi[`PPME_MH_MODE_LO]) begin
         st_d.rd_pin = pol_out(st_d.phase == PH_STROBE && !st_d.is_wr,
                               st_d.ctrl_lo[`PPME_CL_RDP]);
         st_d.wr_pin = pol_out(st_d.phase == PH_STROBE && st_d.is_wr,
                               st_d.ctrl_lo[`PPME_CL_WRP]);
      end else if (master_on) begin
         st_d.rd_pin = pol_out(op && !st_d.is_wr,
                               st_d.ctrl_lo[`PPME_CL_RDP]);
         st_d.wr_pin = pol_out(st_d.phase == PH_STROBE,
                               st_d.ctrl_lo[`PPME_CL_WRP]);
      end else begin
         st_d.rd_pin = pol_out(1'b0, st_d.ctrl_lo[`PPME_CL_RDP]);
         st_d.wr_pin = pol_out(1'b0, st_d.ctrl_lo[`PPME_CL_WRP]);
      end
      st_d.be_pin = pol_out(op && st_d.second,
                            st_d.ctrl_lo[`PPME_CL_BEP]);
      // Synchronous reset: inactive-low pins idle high
      if (reset) begin
         st_d = '0;
         st_d.ctrl_hi = `PPME_RST_REG8;
         st_d.addr = `PPME_RST_ADDR;
         st_d.rd_pin = 1'b1;
         st_d.wr_pin = 1'b1;
         st_d.be_pin = 1'b1;
      end
   end

   // Phase timer load on every phase entry
   assign tload_en = step || sw_go;
   assign tload = phase_len(st_d.phase, wb, wm, we);

   ppme_phase_timer u_timer (
      .clk(clk),
      .reset(reset),
      .load(tload_en),
      .load_val(tload),
      .count(tcount)
   );

   // State register
   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   // Outputs
   assign reg_rdata = st_q.rdata;
   assign port_data_out = st_q.data_out;
   assign port_data_oe = st_q.data_oe;
   assign address_pins = st_q.addr_pins;
   assign read_strobe = st_q.rd_pin;
   assign write_strobe = st_q.wr_pin;
   assign byte_enable_strobe = st_q.be_pin;
   assign busy = busy_w;
   assign irq_pulse = st_q.irq;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_full_latch;
      st_q.phase == PH_LATCH_LO ##1 st_q.phase == PH_LATCH_HI;
   endsequence

   sequence s_enter_strobe3;
      st_q.phase != PH_STROBE ##1 (st_q.phase == PH_STROBE && wm == 4'h3);
   endsequence

   a_mux_none: assert property (sw_go && mux == 2'b00 |=>
      st_q.phase inside {PH_SETUP, PH_STROBE})
      else $error("demultiplexed start entered a latch phase");
   a_mux_partial: assert property (sw_go && mux == 2'b01 |=>
      st_q.phase == PH_LATCH_LO ##1 st_q.phase != PH_LATCH_HI)
      else $error("partial mux latch cycle wrong");
   a_mux_full: assert property (sw_go && mux == 2'b10 |=>
      s_full_latch)
      else $error("full mux latch cycles wrong");
   a_cs_zero: assert property (st_q.phase == PH_LATCH_HI &&
      csf[1] |-> st_q.data_out[7:6] == 2'b00 && st_q.data_oe)
      else $error("chip select bits not zero in high latch");
   a_strobe_hold: assert property (s_enter_strobe3 |->
      st_q.phase == PH_STROBE [*4] ##1
      (st_q.phase != PH_STROBE || tcount == 4'h3))
      else $error("strobe length not middle wait plus one");
   a_single_busy: assert property (sw_go && mux == 2'b00 &&
      wm == 4'h0 && !wide |=> !busy_w)
      else $error("single cycle operation showed busy");
   a_addr_step: assert property (last && increment_mode_field == 2'b01 &&
      csf == 2'b00 && !reg_wr |=> st_q.addr == $past(step_addr))
      else $error("address not stepped at completion");
   a_cs_frozen: assert property (last && csf[1] && !reg_wr |=>
      st_q.addr[15:14] == $past(st_q.addr[15:14]))
      else $error("chip select bits changed by stepping");
   a_irq_done: assert property (last &&
      st_q.mode_hi[`PPME_MH_IRQ_EN] |=> irq_pulse ##1
      (!irq_pulse || $past(last)))
      else $error("completion interrupt missing");
   a_busy_ignore: assert property (busy_w && st_q.is_wr &&
      reg_wr && reg_addr == `PPME_OFS_DIN_LOW |=>
      st_q.din_lo == $past(st_q.din_lo))
      else $error("data register written while busy");

endmodule

// *** dv/ppme_ext_mem.sv ***
// Model of the external memory on the far side of the parallel port.
// Assumes active-high controls; the bench gives the mux and strobe scheme.
`timescale 1ns/1ps
module ppme_ext_mem (
   input wire logic clk,
   input wire logic [1:0] mux,
   input wire logic dir_mode,
   input wire logic [7:0] port_data_out,
   input wire logic port_data_oe,
   input wire logic [15:0] address_pins,
   input wire logic read_strobe,
   input wire logic write_strobe,
   input wire logic byte_enable_strobe,
   output logic [7:0] port_data_in,
   output logic [7:0] lat_hi
);
   logic [7:0] mem [256];
   logic [7:0] lat_lo, last, key;
   logic rd_ev, wr_ev;
   // Fill with a pattern that differs from every write
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'hFF;
      end
      lat_lo = 8'h00;
      // Nonzero so that a missing high latch cycle shows up
      lat_hi = 8'hFF;
      last = 8'h00;
   end
   // Direction plus enable, or separate strobes
   assign rd_ev = dir_mode ? (write_strobe & read_strobe) : read_strobe;
   assign wr_ev = dir_mode ? (write_strobe & ~read_strobe) : write_strobe;
   // Byte enable selects the upper half of the memory
   assign key = {byte_enable_strobe,
      (mux == 2'b00) ? address_pins[6:0] : lat_lo[6:0]};
   // Address latches and write capture
   always @(posedge clk) begin
      if (mux != 2'b00 && address_pins[0] && port_data_oe) begin
         lat_lo <= port_data_out;
      end
      if (mux == 2'b10 && address_pins[1] && port_data_oe) begin
         lat_hi <= port_data_out;
      end
      if (wr_ev) begin
         mem[key] <= port_data_out;
      end
      if (rd_ev) begin
         last <= mem[key];
      end
   end
   // Released bus shows the inverse of the last byte
   assign port_data_in = rd_ev ? mem[key] : ~last;
endmodule

// *** dv/tb_parallel_master_port_engine.sv ***
// Testbench of the parallel master port engine.
// Assumes the external memory model on the far side of the port.
`timescale 1ns/1ps
`include "ppme_defines.svh"
module tb_parallel_master_port_engine;
   localparam logic [3:0] o_ch = `PPME_OFS_CONTROL_HIGH;
   localparam logic [3:0] o_cl = `PPME_OFS_CONTROL_LOW;
   localparam logic [3:0] o_mh = `PPME_OFS_MODE_HIGH;
   localparam logic [3:0] o_wc = `PPME_OFS_WAIT_CFG;
   localparam logic [3:0] o_al = `PPME_OFS_ADDR_LOW;
   localparam logic [3:0] o_ah = `PPME_OFS_ADDR_HIGH;
   localparam logic [3:0] o_dl = `PPME_OFS_DIN_LOW;
   localparam logic [3:0] o_dh = `PPME_OFS_DIN_HIGH;
   logic clk, reset, reg_wr, reg_rd, dm, oe, rds, wrs, bes, busy, irq;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, pdi, pdo, lat_hi, v;
   logic [15:0] apins;
   logic [1:0] mux;
   int num_errors, n_compared, n_stb, n_busy, n_low, s0, s1, s2;
   logic [7:0] wc [3] = '{8'h8D, 8'hC3, 8'h3C};
   int ns [3] = '{4, 1, 16};
   int nb [3] = '{6, 0, 15};
   logic [1:0] cf [5] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h0};
   logic [1:0] im [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
   logic [15:0] sa [5] = '{16'hFFFF, 16'hFFFF, 16'hC000, 16'h8000, 16'h1234};
   logic [15:0] ea [5] = '{16'h0000, 16'hC000, 16'hFFFF, 16'hFFFF, 16'h1234};

   ppme_engine dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .port_data_in(pdi), .port_data_out(pdo),
      .port_data_oe(oe), .address_pins(apins), .read_strobe(rds),
      .write_strobe(wrs), .byte_enable_strobe(bes), .busy(busy),
      .irq_pulse(irq));
   ppme_ext_mem p_u (.clk(clk), .mux(mux), .dir_mode(dm),
      .port_data_out(pdo), .port_data_oe(oe), .address_pins(apins),
      .read_strobe(rds), .write_strobe(wrs), .byte_enable_strobe(bes),
      .port_data_in(pdi), .lat_hi(lat_hi));

   // -----------------------------------------------------------------
   // Clock and pin monitors
   // -----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Strobe, busy and low-level cycle counts
   always @(posedge clk) begin
      if ((rds | wrs) === 1'b1) n_stb <= n_stb + 1;
      if (busy === 1'b1) n_busy <= n_busy + 1;
      if (wrs === 1'b0) n_low <= n_low + 1;
   end

   // -----------------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      chk(v, e);
   endtask
   task automatic go(input logic [7:0] d);
      s0 = n_stb;
      s1 = n_busy;
      s2 = n_low;
      wr(o_dl, d);
   endtask
   task automatic complete_run();
      $display("errors=%0d compared=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait for the completion pulse
   task automatic done();
      int i;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (irq === 1'b1) break;
      end
      if (i == 64) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, irq, 1'b1);
         complete_run();
      end
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial begin
      {reset, reg_wr, reg_rd, dm} = 4'h8;
      {reg_addr, reg_wdata, mux} = 14'h0000;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      chk(wrs, 1'b1);
      for (int a = 0; a < 9; a++) begin
         rdchk(4'(a), 8'h00);
      end
      wr(o_ch, 8'h80);
      wr(o_cl, 8'h3F);
      wr(o_mh, 8'h2A);
      rdchk(o_mh, 8'h2A);
      wr(o_al, 8'h10);
      go(8'hA5);
      done();
      chk(p_u.mem[8'h10], 8'hA5);
      chk(16'(n_busy - s1), 16'h0000);
      rdchk(o_al, 8'h11);
      rdchk(o_dl, 8'hA5);
      done();
      rdchk(o_dl, 8'hEE);
      done();
      // Wait states, with a refused request while busy
      for (int k = 0; k < 3; k++) begin
         wr(o_wc, wc[k]);
         wr(o_al, 8'h60);
         go(8'h11 + 8'(k));
         if (k == 0) wr(o_dl, 8'h99);
         done();
         chk(16'(n_stb - s0), 16'(ns[k]));
         chk(16'(n_busy - s1), 16'(nb[k]));
         chk(p_u.mem[8'h60], 8'h11 + 8'(k));
      end
      wr(o_wc, 8'h00);
      // Address multiplexing schemes with chip selects on
      wr(o_cl, 8'hBF);
      for (int m = 0; m < 3; m++) begin
         mux <= 2'(m);
         wr(o_ch, 8'h80 | 8'(m << 3));
         wr(o_ah, 8'hC0);
         wr(o_al, 8'h20 + 8'(m));
         go(8'h40 + 8'(m));
         done();
         chk(p_u.mem[8'h20 + 8'(m)], 8'h40 + 8'(m));
         chk(16'(n_busy - s1), 16'(m));
      end
      chk(lat_hi, 8'h00);
      // Sixteen-bit write and read
      wr(o_mh, 8'h2E);
      wr(o_al, 8'h30);
      wr(o_dh, 8'h5A);
      go(8'h3C);
      done();
      chk(p_u.mem[8'h30], 8'h3C);
      chk(p_u.mem[8'hB0], 8'h5A);
      chk(16'(n_stb - s0), 16'h0002);
      wr(o_dh, 8'h00);
      wr(o_al, 8'h30);
      rdchk(o_dl, 8'h3C);
      done();
      rdchk(o_dh, 8'h5A);
      // Address stepping with chip select functions
      wr(o_ch, 8'h80);
      mux <= 2'b00;
      for (int k = 0; k < 5; k++) begin
         wr(o_cl, {cf[k], 6'h3F});
         wr(o_mh, {3'b001, im[k], 3'b010});
         wr(o_al, sa[k][7:0]);
         wr(o_ah, sa[k][15:8]);
         go(8'h00);
         done();
         rdchk(o_al, ea[k][7:0]);
         rdchk(o_ah, ea[k][15:8]);
      end
      // Direction plus enable scheme
      dm <= 1'b1;
      wr(o_mh, 8'h23);
      wr(o_al, 8'h50);
      go(8'h77);
      done();
      chk(p_u.mem[8'h50], 8'h77);
      wr(o_al, 8'h11);
      rdchk(o_dl, 8'h77);
      done();
      rdchk(o_dl, 8'hEE);
      // Active-low write strobe
      wr(o_mh, 8'h22);
      dm <= 1'b0;
      wr(o_cl, 8'h00);
      rdchk(o_cl, 8'h00);
      go(8'h00);
      done();
      chk(16'(n_low - s2), 16'h0001);
      chk(wrs, 1'b1);
      complete_run();
   end
endmodule
